// ==== logic/icl_pkg.sv ====
package icl_pkg;

  // Widths of the synchroniser bank
  localparam int unsigned ICL_SYNC_W = 3;

  // Bit positions of the VMEbus-side levels within the synchroniser bank
  localparam int unsigned ICL_SB_GRANTED = 0;
  localparam int unsigned ICL_SB_SLV_REQ = 1;
  localparam int unsigned ICL_SB_SLV_RMW = 2;

  // Reset value of the synchroniser flops
  localparam logic ICL_SYNC_RST = 1'h0;

  // Sequencer states
  typedef enum logic [2:0] {
    ICL_ST_IDLE     = 3'h0,
    ICL_ST_WAIT_VME = 3'h1,
    ICL_ST_RUN      = 3'h2,
    ICL_ST_RETRY    = 3'h3,
    ICL_ST_VME_SLV  = 3'h4,
    ICL_ST_VME_GAP  = 3'h5
  } icl_state_t;

endpackage : icl_pkg

// ==== logic/icl_sync_if.sv ====
`timescale 1ns/1ps
interface icl_sync_if #(
  parameter int unsigned W = 3
);
  logic [W-1:0] raw;
  logic [W-1:0] sync;

  modport owner (output raw, input sync);
  modport bank  (input raw, output sync);
endinterface : icl_sync_if

// ==== logic/icl_sync_bank.sv ====
`timescale 1ns/1ps
module icl_sync_bank
  import icl_pkg::*;
#(
  parameter int unsigned W = ICL_SYNC_W
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic clk_en,
  icl_sync_if.bank  sif
);

  // Refuse an empty bank
  if (W < 1) begin : g_bad_width
    $error("icl_sync_bank: W must be at least 1");
  end

  // Two flops per level; the first is read only by the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        meta_q <= ICL_SYNC_RST;
        sync_q <= ICL_SYNC_RST;
      end else if (clk_en) begin
        meta_q <= sif.raw[i];
        sync_q <= meta_q;
      end
    end
    assign sif.sync[i] = sync_q;
  end

endmodule : icl_sync_bank

// ==== logic/icl_lock.sv ====
`timescale 1ns/1ps
module icl_lock
  import icl_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic multi_rmw_hold_bit,
  input  wire logic cpu_cycle_req,
  input  wire logic cpu_rmw_lock,
  input  wire logic cpu_multi_addr,
  input  wire logic cpu_target_vme,
  input  wire logic cpu_seq_end,
  input  wire logic vme_bus_granted,
  input  wire logic vme_slave_req,
  input  wire logic vme_slave_rmw,
  output logic      cpu_proceed,
  output logic      cpu_lb_grant,
  output logic      cpu_berr,
  output logic      cpu_halt,
  output logic      vme_bus_req,
  output logic      vme_rmw_lock,
  output logic      vme_lb_grant,
  output logic      seq_is_multi
);

  icl_state_t state_q;
  icl_state_t state_d;
  logic       granted_s;
  logic       slv_req_s;
  logic       slv_rmw_s;
  logic       locked_q;
  logic       multi_q;
  logic       start_ok;
  logic       need_vme;
  logic       seq_start;
  logic       seq_clear;

  icl_sync_if #(.W(ICL_SYNC_W)) sif ();

  // Refuse a sync bank too narrow for the three VMEbus levels
  if (ICL_SYNC_W <= ICL_SB_GRANTED || ICL_SYNC_W <= ICL_SB_SLV_REQ
      || ICL_SYNC_W <= ICL_SB_SLV_RMW) begin : g_bad_bank
    $error("icl_lock: sync bank narrower than its level map");
  end

  // Two levels sharing one flop pair would alias two of grant, slave request and slave rmw
  if (ICL_SB_GRANTED == ICL_SB_SLV_REQ || ICL_SB_GRANTED == ICL_SB_SLV_RMW
      || ICL_SB_SLV_REQ == ICL_SB_SLV_RMW) begin : g_bad_map
    $error("icl_lock: sync bank positions overlap");
  end

  // VMEbus levels are asynchronous to the local clock
  assign sif.raw[ICL_SB_GRANTED] = vme_bus_granted;
  assign sif.raw[ICL_SB_SLV_REQ] = vme_slave_req;
  assign sif.raw[ICL_SB_SLV_RMW] = vme_slave_rmw;
  assign granted_s               = sif.sync[ICL_SB_GRANTED];
  assign slv_req_s               = sif.sync[ICL_SB_SLV_REQ];
  assign slv_rmw_s               = sif.sync[ICL_SB_SLV_RMW];

  icl_sync_bank #(.W(ICL_SYNC_W)) u_sync (
    .clk    (clk),
    .reset  (reset),
    .clk_en (clk_en),
    .sif    (sif)
  );

  // Whether a new request must wait for VMEbus mastership
  always_comb begin
    need_vme = 1'h0;
    if (cpu_target_vme) begin
      need_vme = 1'h1;
    end else if (cpu_rmw_lock && cpu_multi_addr && multi_rmw_hold_bit) begin
      // Cost of the hold bit: DRAM-only locked multi-address runs pay for arbitration
      need_vme = 1'h1;
    end
    // Hold bit clear: DRAM-only multi-address runs at once, no lock vs others
    start_ok = !need_vme;
  end

  // Sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ICL_ST_IDLE: begin
        // Slave side wins here between processor sequences; mid-sequence it wins only through a retry
        if (slv_req_s) begin
          state_d = ICL_ST_VME_SLV;
        end else if (cpu_cycle_req) begin
          state_d = start_ok ? ICL_ST_RUN : ICL_ST_WAIT_VME;
        end
      end
      ICL_ST_WAIT_VME: begin
        // Processor holds local bus for a VMEbus cycle: deadlock, so retry
        if (slv_req_s) begin
          state_d = ICL_ST_RETRY;
        end else if (granted_s) begin
          state_d = ICL_ST_RUN;
        end
      end
      ICL_ST_RUN: begin
        if (slv_req_s && cpu_target_vme && !granted_s) begin
          state_d = ICL_ST_RETRY;
        end else if (cpu_seq_end) begin
          state_d = ICL_ST_IDLE;
        end
      end
      ICL_ST_RETRY: begin
        // Processor aborts by dropping its request
        if (!cpu_cycle_req) begin
          state_d = ICL_ST_VME_SLV;
        end
      end
      ICL_ST_VME_SLV: begin
        if (!slv_req_s) begin
          state_d = slv_rmw_s ? ICL_ST_VME_GAP : ICL_ST_IDLE;
        end
      end
      ICL_ST_VME_GAP: begin
        // Local bus may be rearbitrated, but not back to the processor
        if (slv_req_s) begin
          state_d = ICL_ST_VME_SLV;
        end else if (!slv_rmw_s) begin
          state_d = ICL_ST_IDLE;
        end
      end
      default: state_d = ICL_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ICL_ST_IDLE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // A processor sequence starts when idle is left without a slave claim
  assign seq_start = (state_q == ICL_ST_IDLE) && (state_d != ICL_ST_IDLE) && !slv_req_s;
  // Ending or aborting drops the class, so a retried cycle is classed anew
  assign seq_clear = (state_d == ICL_ST_IDLE) || (state_d == ICL_ST_RETRY);

  // Locked flag, taken at the start and kept until the sequence ends or is retried
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      locked_q <= 1'h0;
    end else if (clk_en) begin
      if (seq_start) begin
        locked_q <= cpu_rmw_lock;
      end else if (seq_clear) begin
        locked_q <= 1'h0;
      end
    end
  end

  // Multi-address class; the lock qualifier keeps plain bursts out of it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      multi_q <= 1'h0;
    end else if (clk_en) begin
      if (seq_start) begin
        multi_q <= cpu_rmw_lock && cpu_multi_addr;
      end else if (seq_clear) begin
        multi_q <= 1'h0;
      end
    end
  end

  // Output decode; handshake levels straight from state
  always_comb begin
    cpu_proceed  = 1'h0;
    cpu_lb_grant = 1'h0;
    cpu_berr     = 1'h0;
    cpu_halt     = 1'h0;
    vme_bus_req  = 1'h0;
    vme_rmw_lock = 1'h0;
    vme_lb_grant = 1'h0;
    unique case (state_q)
      ICL_ST_IDLE: begin
        cpu_lb_grant = 1'h1;
      end
      ICL_ST_WAIT_VME: begin
        // Processor keeps the local bus while it waits for mastership
        cpu_lb_grant = 1'h1;
        vme_bus_req  = 1'h1;
      end
      ICL_ST_RUN: begin
        cpu_proceed  = 1'h1;
        cpu_lb_grant = 1'h1;
        // Mastership kept for the whole locked run, not only the first access
        vme_bus_req  = cpu_target_vme || (locked_q && granted_s);
        // Lock only once granted; a DRAM-only locked run claims the VMEbus only when multi-address with the hold bit set
        vme_rmw_lock = locked_q && granted_s;
      end
      ICL_ST_RETRY: begin
        // Retry pair: bus error and halt always rise and fall together
        cpu_lb_grant = 1'h1;
        cpu_berr     = 1'h1;
        cpu_halt     = 1'h1;
      end
      ICL_ST_VME_SLV: begin
        vme_lb_grant = 1'h1;
      end
      ICL_ST_VME_GAP: begin
        // Nobody owns the local bus between the remote halves
        cpu_lb_grant = 1'h0;
      end
      default: begin
        cpu_lb_grant = 1'h0;
      end
    endcase
  end

  // Class flag straight from its flop
  assign seq_is_multi = multi_q;

endmodule : icl_lock

// ==== bench/icl_lock_chk.sv ====
`timescale 1ns/1ps
// Port watch on the lock sequencer
module icl_lock_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic multi_rmw_hold_bit,
  input wire logic cpu_cycle_req,
  input wire logic cpu_target_vme,
  input wire logic cpu_seq_end,
  input wire logic vme_slave_rmw,
  input wire logic cpu_proceed,
  input wire logic cpu_lb_grant,
  input wire logic cpu_berr,
  input wire logic cpu_halt,
  input wire logic vme_bus_req,
  input wire logic vme_rmw_lock,
  input wire logic vme_lb_grant,
  input wire logic seq_is_multi
);
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Gap between remote halves keeps both grants low
  sequence s_gap; !vme_lb_grant && !cpu_lb_grant; endsequence
  property p_excl; vme_lb_grant |-> !cpu_lb_grant && !cpu_proceed; endproperty
  property p_gap; $fell(vme_lb_grant) && vme_slave_rmw |-> s_gap; endproperty
  property p_pair; cpu_berr |-> cpu_halt && !cpu_proceed; endproperty
  property p_keep; cpu_berr && cpu_cycle_req |=> cpu_berr; endproperty
  property p_cause; $rose(cpu_berr) |-> $past(vme_bus_req); endproperty
  property p_lock; $rose(cpu_proceed) && seq_is_multi && multi_rmw_hold_bit |-> vme_bus_req && vme_rmw_lock; endproperty
  property p_stand; cpu_proceed && !cpu_seq_end && !cpu_target_vme |=> cpu_proceed; endproperty
  // Hold bit clear: local work starts without arbitration delay
  property p_fast; $rose(cpu_cycle_req) && !cpu_target_vme && !multi_rmw_hold_bit && !vme_slave_rmw
    |=> cpu_proceed; endproperty
  a_excl: assert property (p_excl) else $error("excl");
  a_gap: assert property (p_gap) else $error("gap");
  a_pair: assert property (p_pair) else $error("pair");
  a_keep: assert property (p_keep) else $error("keep");
  a_cause: assert property (p_cause) else $error("cause");
  a_lock: assert property (p_lock) else $error("lock");
  a_stand: assert property (p_stand) else $error("stand");
  a_fast: assert property (p_fast) else $error("fast");
endmodule : icl_lock_chk
bind icl_lock icl_lock_chk i_icl_lock_chk (.*);

// ==== bench/icl_vme_model.sv ====
`timescale 1ns/1ps
// VMEbus arbiter and one remote master
module icl_vme_model (
  input  wire logic clk,
  input  wire logic vme_bus_req,
  output logic      vme_bus_granted,
  output logic      vme_slave_req,
  output logic      vme_slave_rmw
);
  int   wait_n = 0;
  int   lag_q  = 0;
  logic g_q    = 1'h0;
  assign vme_bus_granted = g_q;
  // Grant after wait_n cycles, gone with the request
  always @(posedge clk) begin
    lag_q <= vme_bus_req ? lag_q + 1 : 0;
    g_q <= vme_bus_req && lag_q >= wait_n;
  end
  initial begin
    vme_slave_req = 1'h0;
    vme_slave_rmw = 1'h0;
  end
  // Read then write half under one rmw level
  task automatic rmw_pair();
    vme_slave_rmw = 1'h1;
    repeat (2) begin
      vme_slave_req = 1'h1;
      repeat (6) @(negedge clk);
      vme_slave_req = 1'h0;
      repeat (4) @(negedge clk);
    end
    vme_slave_rmw = 1'h0;
  endtask : rmw_pair
endmodule : icl_vme_model

// ==== bench/indivisible_cycle_lock_tb_top.sv ====
`timescale 1ns/1ps
module indivisible_cycle_lock_tb_top;
  logic clk = 1'h0, reset = 1'h1, clk_en = 1'h1, seen_q = 1'h0;
  logic multi_rmw_hold_bit, cpu_rmw_lock, cpu_multi_addr, cpu_target_vme, cpu_cycle_req, cpu_seq_end;
  logic vme_bus_granted, vme_slave_req, vme_slave_rmw, cpu_proceed, cpu_lb_grant, cpu_berr;
  logic cpu_halt, vme_bus_req, vme_rmw_lock, vme_lb_grant, seq_is_multi;
  logic [2:0] exp_q[$];
  int errors = 0;
  int n_checks = 0;
  always #12.5 clk = ~clk;
  icl_lock i_icl_lock (.*);
  icl_vme_model i_icl_vme_model (.*);
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic check(input string nm, input logic [2:0] seen, input logic [2:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s exp %b seen %b", nm, exp, seen);
    end
  endtask : check
  // Bounded wait: 0 proceed, 1 retry, 2 slave grant
  task automatic wait_hi(input int w);
    int k;
    k = 0;
    while ((w == 0 ? cpu_proceed : w == 1 ? cpu_berr : vme_lb_grant) !== 1'h1) begin
      @(negedge clk);
      k++;
      if (k > 80) begin
        errors++;
        final_report();
      end
    end
  endtask : wait_hi
  // c = hold, lock, multi, target; one target per sequence
  task automatic run_seq(input logic [3:0] c);
    {multi_rmw_hold_bit, cpu_rmw_lock, cpu_multi_addr, cpu_target_vme} = c;
    cpu_cycle_req = 1'h1;
    exp_q.push_back({c[0] | (c[2] & c[1] & c[3]), c[2] & (c[0] | c[1] & c[3]), c[2] & c[1]});
    wait_hi(0);
    repeat ($urandom_range(1, 4)) @(negedge clk);
    cpu_seq_end = 1'h1;
    @(negedge clk);
    cpu_seq_end = 1'h0;
    cpu_cycle_req = 1'h0;
    repeat (5) @(negedge clk);
  endtask : run_seq
  // Each rise of proceed settles the oldest note
  always @(negedge clk) begin
    if (cpu_proceed === 1'h1 && !seen_q)
      check("proceed", {vme_bus_req, vme_rmw_lock, seq_is_multi}, exp_q.pop_front());
    seen_q <= cpu_proceed === 1'h1;
  end
  initial begin
    {multi_rmw_hold_bit, cpu_rmw_lock, cpu_multi_addr, cpu_target_vme, cpu_cycle_req, cpu_seq_end} = '0;
    void'($urandom(6569));
    repeat (20) @(negedge clk);
    reset = 1'h0;
    repeat (3) @(negedge clk);
    // Every mix at a random grant delay
    for (int i = 0; i < 16; i++) begin
      i_icl_vme_model.wait_n = $urandom_range(0, 6);
      run_seq(i[3:0]);
    end
    // Processor held off across both remote halves
    fork
      i_icl_vme_model.rmw_pair();
      begin
        repeat (4) @(negedge clk);
        run_seq(4'h4);
      end
    join
    // Frozen enable: nothing moves, then mastership first for a held multi run
    i_icl_vme_model.wait_n = 2;
    clk_en = 1'h0;
    fork
      run_seq(4'hE);
      begin
        repeat (4) @(negedge clk);
        check("freeze", {cpu_proceed, vme_bus_req, seq_is_multi}, 3'h0);
        clk_en = 1'h1;
      end
    join
    // Remote master collides with a wait for the VMEbus
    i_icl_vme_model.wait_n = 1000;
    {multi_rmw_hold_bit, cpu_rmw_lock, cpu_multi_addr, cpu_target_vme} = 4'hE;
    cpu_cycle_req = 1'h1;
    repeat (3) @(negedge clk);
    i_icl_vme_model.vme_slave_req = 1'h1;
    wait_hi(1);
    check("retry", {cpu_berr, cpu_halt, cpu_proceed}, 3'h6);
    // Retry must stand while the processor still holds its request
    repeat (2) @(negedge clk);
    check("retry_hold", {cpu_berr, cpu_halt, cpu_lb_grant}, 3'h7);
    cpu_cycle_req = 1'h0;
    wait_hi(2);
    check("slave", {vme_lb_grant, cpu_lb_grant, cpu_berr}, 3'h4);
    i_icl_vme_model.vme_slave_req = 1'h0;
    repeat (6) @(negedge clk);
    final_report();
  end
endmodule : indivisible_cycle_lock_tb_top
